// ===== common/sadc_map.svh
/*
 * Constants of the stereo converter serial output port: word sizes, counts and delays.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

`define SADC_SAMPLE_W 24
`define SADC_SHORT_W 16
`define SADC_INIT_FRAMES 4129
`define SADC_INIT_CNT_W 13
`define SADC_FIFO_DEPTH 32
`define SADC_GD_TENTHS 276
`define SADC_GD_FRAMES ((`SADC_GD_TENTHS + 5) / 10)
`define SADC_BITCNT_W 8
`define SADC_FRAMING_LJ 1'b0
`define SADC_FRAMING_I2S 1'b1

`endif

// ===== common/sadc_pkg.sv
/*
 * Types of the stereo converter serial output port.
 * Assumes the constant header sadc_map.svh is on the include path.
 */
`include "sadc_map.svh"

package sadc_pkg;

	typedef logic [`SADC_SAMPLE_W-1:0] sadc_sample_t;

	typedef enum logic [1:0] {
		SADC_PWRDN = 2'b00,
		SADC_WAIT_EDGE = 2'b01,
		SADC_INIT = 2'b11,
		SADC_RUN = 2'b10
	} sadc_state_t;

endpackage

// ===== core/sadc_delay.sv
/*
 * Group-delay line: holds stereo sample pairs for a fixed number of frames.
 * Assumes one advance pulse per frame and that flush empties the line to zero.
 */
`include "sadc_map.svh"

module sadc_delay
	import sadc_pkg::*;
#(
	parameter int STAGES = 28
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic advance_in,
	input wire logic [`SADC_SAMPLE_W-1:0] left_in,
	input wire logic [`SADC_SAMPLE_W-1:0] right_in,
	output logic [`SADC_SAMPLE_W-1:0] left_out,
	output logic [`SADC_SAMPLE_W-1:0] right_out
);

	sadc_sample_t left_r [STAGES];
	sadc_sample_t right_r [STAGES];

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < STAGES; i++) begin
				left_r[i] <= '0;
				right_r[i] <= '0;
			end
		end else if (flush_in) begin
			for (int i = 0; i < STAGES; i++) begin
				left_r[i] <= '0;
				right_r[i] <= '0;
			end
		end else if (advance_in) begin
			left_r[0] <= left_in;
			right_r[0] <= right_in;
			for (int i = 1; i < STAGES; i++) begin
				left_r[i] <= left_r[i-1];
				right_r[i] <= right_r[i-1];
			end
		end
	end

	assign left_out = left_r[STAGES-1];
	assign right_out = right_r[STAGES-1];

endmodule

// ===== core/sadc_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
module sadc_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [WIDTH-1:0] rd_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (count_r != '0);
	assign push = wr_valid_in && wr_ready_out;
	assign pop = rd_valid_out && rd_ready_in;
	assign rd_data_out = mem[rd_ptr_r];

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr_r] <= wr_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (flush_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// ===== core/sadc_serial_port.sv
/*
 * Serial output port of a stereo 24-bit converter: takes sample pairs from the
 * conversion core, delays them, and shifts them out on the host's bit and frame clocks.
 * Assumes bit clock, frame clock and all controls are synchronous to ref_clk_in,
 * which runs much faster than the bit clock, and the sample source runs at the frame rate.
 */
`include "sadc_map.svh"

module sadc_serial_port
	import sadc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic power_down_n_in,
	input wire logic framing_select_in,
	input wire logic bit_clock_in,
	input wire logic channel_frame_clock_in,
	input wire logic sample_valid_in,
	output logic sample_ready_out,
	input wire logic [`SADC_SAMPLE_W-1:0] sample_left_in,
	input wire logic [`SADC_SAMPLE_W-1:0] sample_right_in,
	output logic serial_sample_out,
	output logic data_valid_out
);

	localparam int GD = `SADC_GD_FRAMES;

	sadc_state_t state_r;
	logic bclk_d_r;
	logic fclk_d_r;
	logic [`SADC_INIT_CNT_W-1:0] init_cnt_r;
	logic [`SADC_BITCNT_W-1:0] bit_idx_r;
	logic [`SADC_SAMPLE_W-1:0] shift_r;
	logic i2s_pend_r;
	logic serial_r;
	logic [`SADC_SAMPLE_W-1:0] out_left_r;
	logic [`SADC_SAMPLE_W-1:0] out_right_r;
	logic [`SADC_SAMPLE_W-1:0] dly_left;
	logic [`SADC_SAMPLE_W-1:0] dly_right;
	logic [2*`SADC_SAMPLE_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic bclk_fall;
	logic bclk_rise;
	logic fclk_rise;
	logic fclk_fall;
	logic fclk_edge;
	logic start_edge;
	logic frame_tick;
	logic running;
	logic powered;
	logic [`SADC_SAMPLE_W-1:0] slot_word;

	function automatic logic [`SADC_SAMPLE_W-1:0] sadc_slot(input logic right_sel,
		input logic [`SADC_SAMPLE_W-1:0] l, input logic [`SADC_SAMPLE_W-1:0] r);
		sadc_slot = right_sel ? r : l;
	endfunction

	assign powered = power_down_n_in;
	assign bclk_fall = bclk_d_r && !bit_clock_in;
	assign bclk_rise = !bclk_d_r && bit_clock_in;
	assign fclk_rise = !fclk_d_r && channel_frame_clock_in;
	assign fclk_fall = fclk_d_r && !channel_frame_clock_in;
	assign fclk_edge = fclk_rise || fclk_fall;
	// The frame starts where the left slot starts: frame high in LJ, low in I2S.
	assign start_edge = (framing_select_in == `SADC_FRAMING_I2S) ? fclk_fall : fclk_rise;
	assign frame_tick = (state_r == SADC_INIT || state_r == SADC_RUN) && start_edge;
	assign running = (state_r == SADC_RUN);

	// The left channel is the frame-high half in LJ and the frame-low half in I2S.
	// At a frame start the output register loads in the same cycle, so the left slot
	// takes the word being loaded; otherwise both channels would be a frame apart.
	assign slot_word = sadc_slot((framing_select_in == `SADC_FRAMING_I2S) ?
		channel_frame_clock_in : !channel_frame_clock_in,
		frame_tick ? (running ? dly_left : '0) : out_left_r, out_right_r);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bclk_d_r <= 1'b0;
			fclk_d_r <= 1'b0;
		end else begin
			bclk_d_r <= bit_clock_in;
			fclk_d_r <= channel_frame_clock_in;
		end
	end

	// Power-down sequencing and the initialization count of frame rising edges.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= SADC_PWRDN;
			init_cnt_r <= '0;
		end else if (!powered) begin
			state_r <= SADC_PWRDN;
			init_cnt_r <= '0;
		end else begin
			if (fclk_rise && state_r != SADC_PWRDN && init_cnt_r != `SADC_INIT_CNT_W'(`SADC_INIT_FRAMES)) begin
				init_cnt_r <= init_cnt_r + 1'b1;
			end
			case (state_r)
				SADC_PWRDN: begin
					state_r <= SADC_WAIT_EDGE;
				end
				SADC_WAIT_EDGE: begin
					if (start_edge) begin
						state_r <= SADC_INIT;
					end
				end
				SADC_INIT: begin
					if (init_cnt_r == `SADC_INIT_CNT_W'(`SADC_INIT_FRAMES)) begin
						state_r <= SADC_RUN;
					end
				end
				SADC_RUN: begin
					state_r <= SADC_RUN;
				end
				default: begin
					state_r <= SADC_PWRDN;
				end
			endcase
		end
	end

	// Edges in the wait state are counted too, so the count starts at the very first rise.
	// The core's samples enter a FIFO, one pair drained per frame into the delay line.
	sadc_fifo #(
		.WIDTH(2*`SADC_SAMPLE_W),
		.DEPTH(`SADC_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.flush_in(!powered),
		.wr_valid_in(sample_valid_in && powered),
		.wr_ready_out(sample_ready_out),
		.wr_data_in({sample_left_in, sample_right_in}),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(fifo_pop),
		.rd_data_out(fifo_data)
	);

	assign fifo_pop = frame_tick;

	sadc_delay #(
		.STAGES(GD)
	) u_delay (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.flush_in(!powered),
		.advance_in(frame_tick),
		.left_in(fifo_valid ? fifo_data[2*`SADC_SAMPLE_W-1:`SADC_SAMPLE_W] : '0),
		.right_in(fifo_valid ? fifo_data[`SADC_SAMPLE_W-1:0] : '0),
		.left_out(dly_left),
		.right_out(dly_right)
	);

	// Output register: both channel words loaded at each frame start, zero until running.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_left_r <= '0;
			out_right_r <= '0;
		end else if (!powered) begin
			out_left_r <= '0;
			out_right_r <= '0;
		end else if (frame_tick) begin
			out_left_r <= running ? dly_left : '0;
			out_right_r <= running ? dly_right : '0;
		end
	end

	// Shifter: a frame edge reloads the slot; bit clock falls advance it.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_r <= '0;
			bit_idx_r <= '0;
			i2s_pend_r <= 1'b0;
			serial_r <= 1'b0;
		end else if (!powered || state_r == SADC_PWRDN || state_r == SADC_WAIT_EDGE) begin
			shift_r <= '0;
			bit_idx_r <= '0;
			i2s_pend_r <= 1'b0;
			serial_r <= 1'b0;
		end else if (fclk_edge) begin
			if (framing_select_in == `SADC_FRAMING_LJ) begin
				serial_r <= slot_word[`SADC_SAMPLE_W-1];
				shift_r <= {slot_word[`SADC_SAMPLE_W-2:0], 1'b0};
				bit_idx_r <= `SADC_BITCNT_W'(1);
				i2s_pend_r <= 1'b0;
			end else begin
				// A bit clock fall that coincides with the frame edge is the skipped clock.
				shift_r <= slot_word;
				bit_idx_r <= '0;
				i2s_pend_r <= !bclk_fall;
			end
		end else if (bclk_fall) begin
			if (i2s_pend_r) begin
				// I2S keeps one bit clock of the old slot before the first bit.
				i2s_pend_r <= 1'b0;
			end else if (bit_idx_r < `SADC_BITCNT_W'(`SADC_SAMPLE_W)) begin
				serial_r <= shift_r[`SADC_SAMPLE_W-1];
				shift_r <= {shift_r[`SADC_SAMPLE_W-2:0], 1'b0};
				bit_idx_r <= bit_idx_r + 1'b1;
			end else begin
				serial_r <= 1'b0;
			end
		end
	end

	assign serial_sample_out = powered ? serial_r : 1'b0;
	assign data_valid_out = running && powered;

	a_pd_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!power_down_n_in |-> !serial_sample_out) else $error("Output not low in power-down");

	a_shift_on_fall: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(serial_r != $past(serial_r)) && powered && $past(powered)
		|-> $past(bclk_fall) || $past(fclk_edge)) else $error("Output moved off a falling edge");

	a_pd_enters: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!power_down_n_in |=> state_r == SADC_PWRDN && !data_valid_out) else $error("No power-down");

	a_init_count: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		data_valid_out |-> init_cnt_r == `SADC_INIT_CNT_W'(`SADC_INIT_FRAMES)) else $error("Valid too early");

	a_init_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		state_r == SADC_INIT |-> out_left_r == '0 && out_right_r == '0) else $error("Nonzero init data");

	a_lj_first_bit: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		fclk_edge && powered && framing_select_in == `SADC_FRAMING_LJ && state_r inside {SADC_INIT, SADC_RUN}
		|=> serial_sample_out == $past(slot_word[`SADC_SAMPLE_W-1])) else $error("LJ MSB late");

	a_tail_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		bclk_fall && !fclk_edge && !i2s_pend_r && powered && bit_idx_r == `SADC_BITCNT_W'(`SADC_SAMPLE_W)
		&& state_r inside {SADC_INIT, SADC_RUN} |=> !serial_sample_out) else $error("Tail bit not zero");

	a_start_edge: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		state_r == SADC_WAIT_EDGE && powered ##1 state_r == SADC_INIT |-> $past(start_edge)) else $error("Bad start edge");

	a_frame_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		frame_tick && running && powered |=> out_left_r == $past(dly_left) && out_right_r == $past(dly_right))
		else $error("Output register not loaded");

endmodule

// ===== testbench/sadc_host_model.sv
/*
 * Audio host model: masters the bit and frame clocks and samples the serial data.
 * Assumes ref_clk_in is the bench clock and the bench calls the tasks.
 */
module sadc_host_model #(
	parameter int HALF = 4,
	parameter int SLOT = 26
) (
	input wire logic ref_clk_in,
	input wire logic framing_select_in,
	input wire logic serial_sample_in,
	output logic bit_clock_out,
	output logic channel_frame_clock_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bit_clock_out = 1'b0;
		channel_frame_clock_out = 1'b0;
	end
	// Parks the frame clock at the second-channel level, so the next slot opens a frame.
	task automatic park();
		@(negedge ref_clk_in);
		bit_clock_out = 1'b0;
		channel_frame_clock_out = framing_select_in;
	endtask
	task automatic slot(input logic lvl, output logic [SLOT-1:0] b);
		for (int i = 0; i < SLOT; i++) begin
			@(negedge ref_clk_in);
			if (i == 0) channel_frame_clock_out = lvl;
			bit_clock_out = 1'b0;
			repeat (HALF - 1) @(negedge ref_clk_in);
			bit_clock_out = 1'b1;
			b[SLOT-1-i] = serial_sample_in;
			repeat (HALF - 1) @(negedge ref_clk_in);
		end
	endtask
	task automatic frame(output logic [SLOT-1:0] l, output logic [SLOT-1:0] r);
		slot(~framing_select_in, l);
		slot(framing_select_in, r);
	endtask
	// Short frames with the bit clock standing still, to count off initialization.
	task automatic fast(input int n);
		repeat (2 * n) begin
			repeat (2) @(negedge ref_clk_in);
			channel_frame_clock_out = ~channel_frame_clock_out;
		end
	endtask
endmodule

// ===== testbench/tb.sv
/*
 * Bench of the serial output port: power-down, initialization count and data streams.
 * Assumes the host model drives the bit and frame clocks.
 */
`include "sadc_map.svh"
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOT = 26;
	logic clk, rst_n, pd_n, fs, valid, ready, sdo, dv, bclk, channel_frame_clock;
	logic [`SADC_SAMPLE_W-1:0] left, right;
	logic [SLOT-1:0] bl, br;
	logic [23:0] wl [64];
	logic [23:0] wr [64];
	int bad_count, samples_checked;
	sadc_serial_port dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .power_down_n_in(pd_n),
		.framing_select_in(fs), .bit_clock_in(bclk), .channel_frame_clock_in(channel_frame_clock),
		.sample_valid_in(valid), .sample_ready_out(ready), .sample_left_in(left),
		.sample_right_in(right), .serial_sample_out(sdo), .data_valid_out(dv));
	sadc_host_model #(.HALF(4), .SLOT(SLOT)) host_u (.ref_clk_in(clk),
		.framing_select_in(fs), .serial_sample_in(sdo), .bit_clock_out(bclk),
		.channel_frame_clock_out(channel_frame_clock));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [23:0] pat(input int k);
		return {k[7:0] ^ 8'h80, 16'h5a3c};
	endfunction
	task automatic end_sim();
		$display("checks=%0d errors=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Splits one slot into the word and the bits trailing it.
	task automatic take(input logic [SLOT-1:0] b, output logic [23:0] w);
		int sh;
		sh = SLOT - 24 - int'(fs);
		w = 24'(b >> sh);
		`CHK(b & ((26'h1 << sh) - 26'h1), 26'h0)
	endtask
	task automatic run_frames(input int n);
		for (int f = 0; f < n; f++) begin
			host_u.frame(bl, br);
			take(bl, wl[f]);
			take(br, wr[f]);
		end
	endtask
	task automatic push(input int lim, output int n);
		n = 0;
		for (int i = 0; i < lim + 8; i++) begin
			@(negedge clk);
			if (n >= lim || ready !== 1'b1) break;
			left = pat(n);
			right = ~pat(n);
			valid = 1'b1;
			n++;
		end
		valid = 1'b0;
	endtask
	task automatic check_stream(input int cnt);
		int f0;
		f0 = 0;
		while (f0 < 63 && wl[f0] === 24'h0) f0++;
		`CHK(f0 >= 27 && f0 <= 30, 1'b1)
		for (int k = 0; k < cnt; k++) begin
			`CHK(wl[f0 + k], pat(k))
			`CHK(wr[f0 + k], ~pat(k))
		end
		`CHK(wl[f0 + cnt], 24'h0)
	endtask
	task automatic t_powerdown(input logic mode);
		@(negedge clk);
		pd_n = 1'b0;
		fs = mode;
		host_u.park();
		host_u.frame(bl, br);
		`CHK(bl | br, 26'h0)
		`CHK(dv, 1'b0)
		@(negedge clk);
		pd_n = 1'b1;
	endtask
	task automatic t_init();
		int i;
		host_u.fast(4127);
		run_frames(1);
		`CHK(wl[0] | wr[0], 24'h0)
		`CHK(dv, 1'b0)
		host_u.fast(1);
		for (i = 0; i < 16 && dv !== 1'b1; i++) @(negedge clk);
		`CHK(dv, 1'b1)
		if (dv !== 1'b1) end_sim();
	endtask
	task automatic t_lj_stream();
		int n;
		push(40, n);
		`CHK(n, 32)
		run_frames(64);
		check_stream(32);
	endtask
	task automatic t_i2s_stream();
		int n;
		push(4, n);
		`CHK(n, 4)
		run_frames(36);
		check_stream(4);
	endtask
	initial begin
		rst_n = 1'b0;
		pd_n = 1'b0;
		fs = 1'b0;
		valid = 1'b0;
		left = 24'h0;
		right = 24'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (20) @(negedge clk);
		`CHK(sdo, 1'b0)
		`CHK(ready, 1'b1)
		rst_n = 1'b1;
		t_powerdown(1'b0);
		t_init();
		t_lj_stream();
		t_powerdown(1'b1);
		t_init();
		t_i2s_stream();
		end_sim();
	end
endmodule
